// File: src/cssc_defines.svh
/*
 Register offsets, field positions, reset values and timing counts for the
 converter configuration block. Assumes inclusion by bare name.
*/
`ifndef CSSC_DEFINES_SVH
`define CSSC_DEFINES_SVH
// ==================================================================
// Command codes
`define CSSC_CMD_MISC_USER 8'hd1
`define CSSC_CMD_SHARE 8'hd2
// ==================================================================
// Misc user word fields
`define CSSC_MU_SYNC_EXT 6
`define CSSC_MU_SYNC_OUT 5
`define CSSC_MU_LS_ON 2
`define CSSC_MU_STBY_HI 1
`define CSSC_MU_STBY_LO 0
// ==================================================================
// Share word fields
`define CSSC_SH_ID_HI 15
`define CSSC_SH_ID_LO 8
`define CSSC_SH_CNT_HI 7
`define CSSC_SH_CNT_LO 5
`define CSSC_SH_POS_HI 4
`define CSSC_SH_POS_LO 2
`define CSSC_SH_EN 0
`define CSSC_SH_ID_MAX 8'h1f
// ==================================================================
// Reset values
`define CSSC_MU_RESET 16'h0000
`define CSSC_SH_RESET 16'h0000
// ==================================================================
// Timing: pulsed standby monitor period
`define CSSC_PULSE_NS 1000
`define CSSC_CLK_NS 10
`define CSSC_PULSE_CYC (`CSSC_PULSE_NS / `CSSC_CLK_NS)
`endif

// File: src/cssc_pkg.sv
/*
 Types for the converter configuration block. Assumes nothing else.
*/
package cssc_pkg;
   typedef enum logic [1:0] {
      CSSC_STBY_LOWPWR = 2'h0,
      CSSC_STBY_ALWAYS = 2'h1,
      CSSC_STBY_RSVD = 2'h2,
      CSSC_STBY_PULSED = 2'h3
   } cssc_stby_t;
   typedef struct packed {
      logic [7:0] rail_id;
      logic [3:0] members;
      logic [3:0] position;
      logic enabled;
   } cssc_share_t;
endpackage

// File: src/cssc_pulse_div.sv
/*
 Divider that emits a one-cycle enable pulse every DIV cycles while run_i is
 high. Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module cssc_pulse_div #(
   parameter int DIV = 100
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic run_i,
   output logic tick_o
);
   logic [15:0] cnt_r;
   // ==================================================================
   // Counter
   // Counts down and pulses on wrap; stopped counter restarts from full.
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_r <= 16'h0000;
         tick_o <= 1'b0;
      end else if (!run_i) begin
         cnt_r <= 16'(DIV - 1);
         tick_o <= 1'b0;
      end else if (cnt_r == 16'h0000) begin
         cnt_r <= 16'(DIV - 1);
         tick_o <= 1'b1;
      end else begin
         cnt_r <= cnt_r - 16'h0001;
         tick_o <= 1'b0;
      end
   end
endmodule

// File: src/cssc_config.sv
/*
 Configuration logic for switch-clock use, low-side drive while disabled,
 standby monitoring and the current-share setup word. Assumes a management
 bus front end that decodes word transactions into one-cycle write and read
 strobes carrying a command code, all synchronous to sys_clk_i.
*/
// What this block does
// - Bit6 clear: frequency from strap and parameter.
// - Bit6 set: switch from external clock.
// - Bit5 clear: switch-clock pin never driven.
// - Bit5 set, internal oscillator: drive clock out.
// - Disabled: low-side drive follows bit2.
// - Standby 00: low power, telemetry read faults.
// - Standby 01: continuous monitoring, telemetry available.
// - Standby 11 pulsed monitoring; host avoids 10.
// - Share word bits 15:8 hold rail id.
// - Bits 7:5 give member count minus one.
// - Bits 4:2 give position minus one.
// - Bit 0 enables share rail membership.
`timescale 1ns/1ps
`include "cssc_defines.svh"
module cssc_config import cssc_pkg::*; #(
   parameter int PULSE_CYC = `CSSC_PULSE_CYC
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic wr_stb_i,
   input wire logic rd_stb_i,
   input wire logic [7:0] cmd_i,
   input wire logic [15:0] wdata_i,
   input wire logic telem_rd_i,
   input wire logic conv_enabled_i,
   input wire logic freq_strap_i,
   input wire logic int_osc_clk_i,
   input wire logic sync_pin_i,
   input wire logic pwm_low_i,
   input wire logic cml_clear_i,
   output logic [15:0] rdata_o,
   output logic rvalid_o,
   output logic cmd_unsup_o,
   output logic sync_out_o,
   output logic sync_oe_o,
   output logic sw_clk_o,
   output logic use_strap_freq_o,
   output logic freq_strap_o,
   output logic low_side_on_o,
   output logic low_power_o,
   output logic monitor_en_o,
   output logic telem_avail_o,
   output logic comm_fault_status_o,
   output cssc_share_t share_o
);
   logic [15:0] misc_user_setup_r;
   logic [15:0] current_share_setup_r;
   logic pulse_tick;
   cssc_stby_t stby_mode;
   logic standby;
   assign stby_mode = cssc_stby_t'(misc_user_setup_r[`CSSC_MU_STBY_HI:`CSSC_MU_STBY_LO]);
   // The strap level is taken from the pin itself, so freq_strap_i is left unread.
   // A disabled converter counts as standby for every mode below.
   assign standby = !conv_enabled_i;
   // ==================================================================
   // Register writes
   // Writes to any other command code are dropped without a flag.
   // word write storage.
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         misc_user_setup_r <= `CSSC_MU_RESET;
         current_share_setup_r <= `CSSC_SH_RESET;
      end else if (wr_stb_i) begin
         if (cmd_i == `CSSC_CMD_MISC_USER) begin
            misc_user_setup_r <= wdata_i;
         end else if (cmd_i == `CSSC_CMD_SHARE) begin
            current_share_setup_r <= wdata_i;
         end
      end
   end
   // ==================================================================
   // Register reads
   // Unknown codes answer with zero data and a one-cycle flag.
   // The read data hold their value until the next read strobe.
   // read back stored words.
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_o <= 16'h0000;
         rvalid_o <= 1'b0;
         cmd_unsup_o <= 1'b0;
      end else begin
         rvalid_o <= 1'b0;
         cmd_unsup_o <= 1'b0;
         if (rd_stb_i) begin
            if (cmd_i == `CSSC_CMD_MISC_USER) begin
               rdata_o <= misc_user_setup_r;
               rvalid_o <= 1'b1;
            end else if (cmd_i == `CSSC_CMD_SHARE) begin
               rdata_o <= current_share_setup_r;
               rvalid_o <= 1'b1;
            end else begin
               rdata_o <= 16'h0000;
               cmd_unsup_o <= 1'b1;
            end
         end
      end
   end
   // ==================================================================
   // Switch-clock pin and frequency source
   // The pin is driven only with bit 5 set and the internal oscillator in use.
   // The strap is resampled each cycle while the internal oscillator runs.
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync_out_o <= 1'b0;
         sync_oe_o <= 1'b0;
         sw_clk_o <= 1'b0;
         use_strap_freq_o <= 1'b1;
         freq_strap_o <= 1'b0;
      end else begin
         if (misc_user_setup_r[`CSSC_MU_SYNC_EXT]) begin
            sw_clk_o <= sync_pin_i;
            use_strap_freq_o <= 1'b0;
            sync_oe_o <= 1'b0;
            sync_out_o <= 1'b0;
         end else begin
            sw_clk_o <= int_osc_clk_i;
            use_strap_freq_o <= 1'b1;
            freq_strap_o <= sync_pin_i;
            sync_oe_o <= misc_user_setup_r[`CSSC_MU_SYNC_OUT];
            sync_out_o <= misc_user_setup_r[`CSSC_MU_SYNC_OUT] & int_osc_clk_i;
         end
      end
   end
   // ==================================================================
   // Low-side drive
   // While enabled, the modulator's low-side request is registered and appears one cycle later.
   // disabled low-side drive.
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         low_side_on_o <= 1'b0;
      end else if (standby) begin
         low_side_on_o <= misc_user_setup_r[`CSSC_MU_LS_ON];
      end else begin
         low_side_on_o <= pwm_low_i;
      end
   end
   // ==================================================================
   // Pulsed monitor timebase
   // Ticks only while disabled in pulsed standby, once every PULSE_CYC cycles.
   cssc_pulse_div #(
      .DIV(PULSE_CYC)
   ) u_div (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .run_i(standby && stby_mode == CSSC_STBY_PULSED),
      .tick_o(pulse_tick)
   );
   // ==================================================================
   // Standby behaviour
   // Reserved code 10 is treated like continuous monitoring, the safe case.
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         low_power_o <= 1'b0;
         monitor_en_o <= 1'b1;
         telem_avail_o <= 1'b1;
      end else if (!standby) begin
         low_power_o <= 1'b0;
         monitor_en_o <= 1'b1;
         telem_avail_o <= 1'b1;
      end else begin
         case (stby_mode)
            CSSC_STBY_LOWPWR: begin
               low_power_o <= 1'b1;
               monitor_en_o <= 1'b0;
               telem_avail_o <= 1'b0;
            end
            // Pulsed mode wakes the monitor on each tick and on telemetry reads.
            // pulsed monitoring.
            CSSC_STBY_PULSED: begin
               low_power_o <= 1'b0;
               monitor_en_o <= pulse_tick | telem_rd_i;
               telem_avail_o <= 1'b1;
            end
            default: begin
               low_power_o <= 1'b0;
               monitor_en_o <= 1'b1;
               telem_avail_o <= 1'b1;
            end
         endcase
      end
   end
   // ==================================================================
   // Communication fault flag
   // A faulting read and a clear in the same cycle leave the flag set.
   // telemetry read fault; set wins over clear.
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         comm_fault_status_o <= 1'b0;
      end else if (telem_rd_i && standby && stby_mode == CSSC_STBY_LOWPWR) begin
         comm_fault_status_o <= 1'b1;
      end else if (cml_clear_i) begin
         comm_fault_status_o <= 1'b0;
      end
   end
   // ==================================================================
   // Share configuration outputs
   // Count and position are stored minus one, so one is added here.
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         share_o <= '0;
      end else begin
         share_o.rail_id <= current_share_setup_r[`CSSC_SH_ID_HI:`CSSC_SH_ID_LO];
         share_o.members <= {1'b0, current_share_setup_r[`CSSC_SH_CNT_HI:`CSSC_SH_CNT_LO]} + 4'h1;
         share_o.position <= {1'b0, current_share_setup_r[`CSSC_SH_POS_HI:`CSSC_SH_POS_LO]} + 4'h1;
         share_o.enabled <= current_share_setup_r[`CSSC_SH_EN];
      end
   end
endmodule

// File: tb/cssc_config_properties.sv
/* Concurrent checks on the configuration block ports.
   Assumes it is bound onto cssc_config with one clock and reset. */
`timescale 1ns/1ps
module cssc_config_chk import cssc_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic wr_stb_i,
   input wire logic rd_stb_i,
   input wire logic [7:0] cmd_i,
   input wire logic [15:0] wdata_i,
   input wire logic telem_rd_i,
   input wire logic int_osc_clk_i,
   input wire logic sync_pin_i,
   input wire logic cml_clear_i,
   input wire logic [15:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic cmd_unsup_o,
   input wire logic sync_oe_o,
   input wire logic sw_clk_o,
   input wire logic use_strap_freq_o,
   input wire logic low_power_o,
   input wire logic telem_avail_o,
   input wire logic comm_fault_status_o,
   input wire cssc_share_t share_o
);
   // ==========================================
   // Port relations, all in the one clock domain.
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   chk_read_known: assert property (
      rd_stb_i && (cmd_i == 8'hd1 || cmd_i == 8'hd2) |=> rvalid_o && !cmd_unsup_o) else $error("read not answered");
   chk_read_other: assert property (
      rd_stb_i && cmd_i != 8'hd1 && cmd_i != 8'hd2 |=> cmd_unsup_o && rdata_o == 16'h0000) else $error("bad unsup");
   chk_share_fields: assert property (
      wr_stb_i && cmd_i == 8'hd2 |-> ##2 share_o == {$past(wdata_i[15:8], 2), {1'b0, $past(wdata_i[7:5], 2)} + 4'h1,
      {1'b0, $past(wdata_i[4:2], 2)} + 4'h1, $past(wdata_i[0], 2)}) else $error("share fields wrong");
   chk_fault_set: assert property (
      telem_rd_i && low_power_o |-> ##[1:2] comm_fault_status_o) else $error("fault not raised");
   chk_fault_sticky: assert property (
      comm_fault_status_o && !cml_clear_i |=> comm_fault_status_o) else $error("fault dropped");
   chk_lowpwr_telem: assert property (
      low_power_o |-> !telem_avail_o) else $error("telemetry in low power");
   chk_pin_drive: assert property (
      sync_oe_o |-> use_strap_freq_o) else $error("pin driven with external clock");
   chk_ext_clock: assert property (
      !use_strap_freq_o && !$past(use_strap_freq_o) |-> sw_clk_o == $past(sync_pin_i)) else $error("ext clock");
   chk_int_clock: assert property (
      use_strap_freq_o && $past(use_strap_freq_o) && !$past(reset_i) |-> sw_clk_o == $past(int_osc_clk_i))
      else $error("int clock");
endmodule
bind cssc_config cssc_config_chk u_chk (.*);

// File: tb/cssc_pin_peer.sv
/* Far side of the switch-clock pin: an external clock source.
   Assumes the device pin drive and enable are fed in. */
`timescale 1ns/1ps
module cssc_pin_peer (
   input wire logic sys_clk_i,
   input wire logic sync_out_i,
   input wire logic sync_oe_i,
   output logic pin_o
);
   logic [1:0] div_r = 2'h0;
   logic ext_clk_r = 1'b0;
   // ==========================================
   // external clock source
   // Toggles every third falling edge so it differs from the oscillator.
   always_ff @(negedge sys_clk_i) begin
      div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
      if (div_r == 2'h2) begin
         ext_clk_r <= ~ext_clk_r;
      end
   end
   // pin level resolution
   // The device drive wins while enabled, otherwise the external source.
   assign pin_o = sync_oe_i ? sync_out_i : ext_clk_r;
endmodule

// File: tb/tb_top.sv
/* Self-checking bench for the configuration block.
   Assumes the design and its package are compiled first. */
`timescale 1ns/1ps
module tb_top import cssc_pkg::*;;
   logic sys_clk_i = 1'b0, reset_i = 1'b1, wr_stb_i = 1'b0, rd_stb_i = 1'b0, telem_rd_i = 1'b0;
   logic conv_enabled_i = 1'b0, freq_strap_i = 1'b0, int_osc_clk_i = 1'b0, pwm_low_i = 1'b0, cml_clear_i = 1'b0;
   logic [7:0] cmd_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000, rdata_o;
   logic sync_pin_i, rvalid_o, cmd_unsup_o, sync_out_o, sync_oe_o, sw_clk_o, use_strap_freq_o, freq_strap_o;
   logic low_side_on_o, low_power_o, monitor_en_o, telem_avail_o, comm_fault_status_o;
   cssc_share_t share_o;
   int n_fail = 0, tests_run = 0, cycles = 0;
   logic [15:0] sh [3] = '{16'h1ffd, 16'h0548, 16'h0000};
   logic [16:0] se [3] = '{17'h03f11, 17'h00a66, 17'h00022};
   logic [15:0] mu [6] = '{16'h0004, 16'h0020, 16'h0061, 16'h0003, 16'h0001, 16'h0000};
   logic [4:0] me [6] = '{5'b10110, 5'b01110, 5'b00001, 5'b00101, 5'b00101, 5'b00110};
   logic [16:0] pulses = 17'h00000;
   cssc_config #(.PULSE_CYC(4)) DUT (.*);
   cssc_pin_peer PEER (.sys_clk_i(sys_clk_i), .sync_out_i(sync_out_o), .sync_oe_i(sync_oe_o), .pin_o(sync_pin_i));
   // ==========================================
   // Clock, oscillator and hang guard.
   always #5 sys_clk_i = ~sys_clk_i;
   always @(negedge sys_clk_i) int_osc_clk_i <= ~int_osc_clk_i;
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 1000) begin
         n_fail++;
         end_sim();
      end
   end
   // Prints the verdict and stops.
   task end_sim;
      if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Compares one value and counts it.
   task chk(input logic [16:0] got, input logic [16:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Raises one input for a single cycle.
   task automatic pulse(ref logic s);
      @(negedge sys_clk_i);
      s = 1'b1;
      @(negedge sys_clk_i);
      s = 1'b0;
   endtask
   // Word write, then waits until derived outputs have settled.
   task wr(input logic [7:0] c, input logic [15:0] d);
      cmd_i = c;
      wdata_i = d;
      pulse(wr_stb_i);
      repeat (2) @(negedge sys_clk_i);
   endtask
   // Word read, checked in the cycle after the strobe.
   task rd(input logic [7:0] c, input logic [15:0] exp, input logic uns);
      cmd_i = c;
      pulse(rd_stb_i);
      chk({cmd_unsup_o, rdata_o}, {uns, exp});
      chk(rvalid_o, !uns);
   endtask
   // ==========================================
   // Main sequence.
   initial begin
      repeat (4) @(negedge sys_clk_i);
      reset_i = 1'b0;
      rd(8'hd1, 16'h0000, 1'b0);
      rd(8'hd2, 16'h0000, 1'b0);
      rd(8'hd3, 16'h0000, 1'b1);
      // share words with rail ids 31, 5 and 0 are written, decoded and read back.
      for (int i = 0; i < 3; i++) begin
         wr(8'hd2, sh[i]);
         chk(share_o, se[i]);
         rd(8'hd2, sh[i], 1'b0);
      end
      // the reserved standby code 10 is never written.
      for (int i = 0; i < 6; i++) begin
         wr(8'hd1, mu[i]);
         chk({low_side_on_o, sync_oe_o, use_strap_freq_o, low_power_o, telem_avail_o}, me[i]);
         chk(sw_clk_o, mu[i][6] ? sync_pin_i : int_osc_clk_i);
         chk(sync_out_o, mu[i][5] & !mu[i][6] & int_osc_clk_i);
         if (!mu[i][6] && !mu[i][5]) chk(freq_strap_o, sync_pin_i);
         rd(8'hd1, mu[i], 1'b0);
      end
      pulse(telem_rd_i);
      @(negedge sys_clk_i);
      chk(comm_fault_status_o, 1'b1);
      pulse(cml_clear_i);
      @(negedge sys_clk_i);
      chk(comm_fault_status_o, 1'b0);
      // Enabled: low-side follows the modulator and telemetry reads are legal.
      conv_enabled_i = 1'b1;
      pwm_low_i = 1'b1;
      @(negedge sys_clk_i);
      chk({low_side_on_o, low_power_o, monitor_en_o, telem_avail_o}, 4'b1011);
      pulse(telem_rd_i);
      @(negedge sys_clk_i);
      chk(comm_fault_status_o, 1'b0);
      // Disabled in pulsed standby: one monitor pulse every 4 cycles.
      conv_enabled_i = 1'b0;
      pwm_low_i = 1'b0;
      wr(8'hd1, 16'h0003);
      repeat (16) begin
         @(negedge sys_clk_i);
         pulses = pulses + {16'h0000, monitor_en_o};
      end
      chk(pulses, 17'h00004);
      // Reset in mid-run returns both words to zero.
      reset_i = 1'b1;
      @(negedge sys_clk_i);
      reset_i = 1'b0;
      rd(8'hd1, 16'h0000, 1'b0);
      rd(8'hd2, 16'h0000, 1'b0);
      end_sim();
   end
endmodule
